// *** hw/sccs_top.sv ***
// Local design decisions: the address map and the Wishbone interface to the registers.
module sccs_top
	import sccs_pkg::*;
#(
	parameter int ADR_W = 4
)(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	input  wire logic [2:0]       cfg_mode_i,
	input  wire logic             cfg_fail_safe_en_i,
	input  wire logic             cfg_two_speed_en_i,
	input  wire logic             wake_i,
	input  wire logic             crystal_in_pin_i,
	output logic                  crystal_out_pin_o,
	output logic                  crystal_out_pin_oe_o,
	output logic                  crystal_in_free_o,
	output logic                  crystal_out_free_o,
	output logic      [1:0]       amp_gain_o,
	output logic                  sys_tick_o,
	output logic                  exec_run_o
);

	typedef enum logic [1:0] {SW_INTERNAL, SW_TO_EXT, SW_EXTERNAL} sccs_sw_e;

	sccs_mode_e  mode_r;
	logic        fse_r;
	logic        tse_r;
	logic [2:0]  freq_r;
	logic        choice_r;
	logic        outside_r;
	logic        fail_r;
	sccs_sw_e    sw_r;
	sccs_sw_e    sw_nxt;
	logic        ack_r;
	logic [31:0] dat_r;
	logic        tick_r;
	logic        run_r;
	logic [1:0]  div4_r;
	logic        cout_r;
	logic        cout_oe_r;
	logic        in_free_r;
	logic        out_free_r;
	logic [1:0]  gain_r;
	logic [WARM_W-1:0] fast_warm_r;
	logic [WARM_W-1:0] slow_warm_r;
	logic [31:0] ctrl_rd;
	logic [31:0] stat_rd;

	logic fast_base_w;
	logic fast_tick_w;
	logic slow_tick_w;
	logic ext_edge_w;
	logic ost_done_w;
	logic lost_w;

	// Internal oscillators as enable pulses
	sccs_div #(.W(2)) u_fast_base (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.en_i   (1'b1),
		.lim_i  (FAST_LIM[1:0]),
		.tick_o (fast_base_w)
	);

	sccs_div #(.W(7)) u_fast_scale (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.en_i   (fast_base_w),
		.lim_i  (fast_scale(freq_r)),
		.tick_o (fast_tick_w)
	);

	sccs_div #(.W(10)) u_slow (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.en_i   (1'b1),
		.lim_i  (SLOW_LIM[9:0]),
		.tick_o (slow_tick_w)
	);

	sccs_mon u_mon (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.restart_i  (wake_i),
		.pin_i      (crystal_in_pin_i),
		.edge_o     (ext_edge_w),
		.ost_done_o (ost_done_w),
		.lost_o     (lost_w)
	);

	wire xtal_w      = is_crystal(mode_r);
	wire ext_mode_w  = is_external(mode_r);
	wire two_spd_w   = tse_r && xtal_w;
	wire slow_sel_w  = freq_r == FREQ_SLOW;
	wire fast_st_w   = fast_warm_r == WARM_TICKS[WARM_W-1:0];
	wire slow_st_w   = slow_warm_r == WARM_TICKS[WARM_W-1:0];
	wire int_tick_w  = slow_sel_w ? slow_tick_w : fast_tick_w;
	wire int_st_w    = slow_sel_w ? slow_st_w : fast_st_w;
	wire want_ext_w  = ext_mode_w && !choice_r && !fail_r;
	wire ext_ready_w = !xtal_w || ost_done_w;
	wire on_ext_w    = sw_r == SW_EXTERNAL;
	wire sys_tick_w  = on_ext_w ? ext_edge_w : int_tick_w;
	wire hold_w      = on_ext_w && xtal_w && !ost_done_w;
	wire fail_set_w  = fse_r && ext_mode_w && on_ext_w && lost_w;
	wire cout_mode_w = mode_r inside {MODE_RC, MODE_INT_CLOCK_OUT_PIN};
	wire out_free_w  = mode_r inside {MODE_DRIVEN, MODE_RC_FREE, MODE_INT_FREE};
	wire in_free_w   = mode_r inside {MODE_INT_CLOCK_OUT_PIN, MODE_INT_FREE};

	wire req_w     = wb_cyc_i && wb_stb_i && !ack_r;
	wire hit_ctl_w = wb_adr_i == OSC_CTRL_ADR[ADR_W-1:0];
	wire hit_st_w  = wb_adr_i == STATUS_ADR[ADR_W-1:0];
	wire wr_ctl_w  = req_w && wb_we_i && wb_sel_i[0] && hit_ctl_w;
	wire rd_ctl_w  = req_w && !wb_we_i && hit_ctl_w;
	wire [31:0] rd_w = hit_ctl_w ? ctrl_rd : (hit_st_w ? stat_rd : 32'h0000_0000);

	// Bit 7 is never assigned, so it reads zero
	always_comb
	begin
		ctrl_rd                  = '0;
		ctrl_rd[FREQ_LSB +: 3]   = freq_r;
		ctrl_rd[OUTSIDE_BIT]     = outside_r;
		ctrl_rd[FAST_ST_BIT]     = fast_st_w;
		ctrl_rd[SLOW_ST_BIT]     = slow_st_w;
		ctrl_rd[CHOICE_BIT]      = choice_r;
		stat_rd                  = '0;
		stat_rd[ST_MODE_LSB +: 3] = mode_r;
		stat_rd[ST_FAIL_BIT]     = fail_r;
		stat_rd[ST_OST_BIT]      = ost_done_w;
		stat_rd[ST_TWO_BIT]      = tse_r;
		stat_rd[ST_FAIL_SAFE_CLOCK_MONITOR_BIT]     = fse_r;
	end

	// Fail and two-speed wake go internal at once; other switches wait until the target source is known to run
	always_comb
	begin
		sw_nxt = sw_r;
		unique case (sw_r)
			SW_INTERNAL:
				if (want_ext_w)
					sw_nxt = SW_TO_EXT;
			SW_TO_EXT:
				if (!want_ext_w)
					sw_nxt = SW_INTERNAL;
				else if (ext_ready_w && ext_edge_w)
					sw_nxt = SW_EXTERNAL;
			SW_EXTERNAL:
				if (fail_r || (!want_ext_w && int_st_w) || (wake_i && two_spd_w))
					sw_nxt = SW_INTERNAL;
		endcase
	end

	// Options are caught while reset is held, fixed like programmed fuses
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mode_r <= sccs_mode_e'(cfg_mode_i);
			fse_r  <= cfg_fail_safe_en_i;
			tse_r  <= cfg_two_speed_en_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			freq_r   <= FREQ_RST;
			choice_r <= 1'b0;
		end
		else if (wr_ctl_w)
		begin
			freq_r   <= wb_dat_i[FREQ_LSB +: 3];
			choice_r <= wb_dat_i[CHOICE_BIT];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sw_r <= (outside_at_reset(sccs_mode_e'(cfg_mode_i), cfg_fail_safe_en_i,
				cfg_two_speed_en_i) && is_external(sccs_mode_e'(cfg_mode_i)))
				? SW_EXTERNAL : SW_INTERNAL;
			outside_r <= outside_at_reset(sccs_mode_e'(cfg_mode_i), cfg_fail_safe_en_i,
				cfg_two_speed_en_i);
			fail_r    <= 1'b0;
		end
		else
		begin
			sw_r      <= sw_nxt;
			outside_r <= sw_nxt == SW_EXTERNAL;
			fail_r    <= fail_r || fail_set_w;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fast_warm_r <= '0;
			slow_warm_r <= '0;
		end
		else
		begin
			fast_warm_r <= warm_step(fast_warm_r, fast_base_w);
			slow_warm_r <= warm_step(slow_warm_r, slow_tick_w);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tick_r <= 1'b0;
			run_r  <= 1'b0;
			div4_r <= '0;
		end
		else
		begin
			tick_r <= sys_tick_w;
			run_r  <= !hold_w;
			if (sys_tick_w)
				div4_r <= div4_r + 1'b1;
		end
	end

	// Gain is a static decode of the mode
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cout_r     <= 1'b0;
			cout_oe_r  <= 1'b0;
			in_free_r  <= 1'b0;
			out_free_r <= 1'b0;
			gain_r     <= GAIN_OFF;
		end
		else
		begin
			cout_r     <= cout_mode_w && div4_r[1];
			cout_oe_r  <= cout_mode_w;
			in_free_r  <= in_free_w;
			out_free_r <= out_free_w;
			gain_r     <= mode_r == MODE_WATCH ? GAIN_LOW :
				mode_r == MODE_MED_XTAL ? GAIN_MED :
				mode_r == MODE_HIGH_XTAL ? GAIN_HIGH : GAIN_OFF;
		end
	end

	// Unmapped addresses still ack, reading zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			dat_r <= '0;
		end
		else
		begin
			ack_r <= req_w;
			if (req_w && !wb_we_i)
				dat_r <= rd_w;
		end
	end

	assign wb_ack_o             = ack_r;
	assign wb_dat_o             = dat_r;
	assign sys_tick_o           = tick_r;
	assign exec_run_o           = run_r;
	assign crystal_out_pin_o    = cout_r;
	assign crystal_out_pin_oe_o = cout_oe_r;
	assign crystal_in_free_o    = in_free_r;
	assign crystal_out_free_o   = out_free_r;
	assign amp_gain_o           = gain_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	chk_unimpl_reads_zero: assert property (
		$past(rd_ctl_w) |-> wb_ack_o && !wb_dat_o[UNIMPL_BIT])
		else $error("unimplemented bit read nonzero");

	chk_freq_write_lands: assert property (
		wr_ctl_w |=> freq_r == $past(wb_dat_i[FREQ_LSB +: 3]))
		else $error("frequency field not written");

	chk_outside_follows: assert property (
		!$past(rst_i) |-> outside_r == (sw_r == SW_EXTERNAL))
		else $error("outside flag disagrees with source");

	chk_choice_internal: assert property (
		choice_r && int_st_w && on_ext_w |=> sw_r == SW_INTERNAL ##1 !outside_r)
		else $error("choice bit did not move to internal");

	chk_fail_moves: assert property (
		fail_set_w |=> fail_r ##1 sw_r == SW_INTERNAL)
		else $error("lost clock not replaced");

	chk_ost_holds: assert property (
		hold_w |=> !exec_run_o)
		else $error("execution ran before start-up count");

	chk_no_ost_wait: assert property (
		!xtal_w |=> exec_run_o)
		else $error("start-up wait outside crystal modes");

	chk_rc_clock_out: assert property (
		mode_r == MODE_RC |=> crystal_out_pin_oe_o && crystal_out_pin_o == $past(div4_r[1]))
		else $error("divided clock not driven");

	chk_pin_release: assert property (
		out_free_w |=> crystal_out_free_o && !crystal_out_pin_oe_o)
		else $error("crystal out pin not released");

	chk_gain_map: assert property (
		mode_r == MODE_HIGH_XTAL |=> amp_gain_o == GAIN_HIGH)
		else $error("wrong amplifier gain");

	chk_slow_source: assert property (
		!on_ext_w && slow_sel_w |=> sys_tick_o == $past(slow_tick_w))
		else $error("slow oscillator not used for 000");

	chk_handover_ready: assert property (
		sw_r == SW_TO_EXT ##1 sw_r == SW_EXTERNAL |-> $past(ext_ready_w && ext_edge_w))
		else $error("handover before target ran");

endmodule : sccs_top

// *** shared/sccs_pkg.sv ***
package sccs_pkg;

	localparam int CLK_HZ        = 25000000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int FAST_HZ       = 8000000;
	localparam int SLOW_HZ       = 31000;
	localparam int FAST_LIM      = CLK_HZ / FAST_HZ - 1;
	localparam int SLOW_LIM      = CLK_HZ / SLOW_HZ - 1;
	localparam int FAIL_TIME_NS  = 2000;
	localparam int FAIL_CYC      = (FAIL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OST_COUNT     = 1024;
	localparam int WARM_TICKS    = 16;
	localparam int WARM_W        = $clog2(WARM_TICKS + 1);

	localparam logic [3:0] OSC_CTRL_ADR = 4'h0;
	localparam logic [3:0] STATUS_ADR   = 4'h4;

	localparam int UNIMPL_BIT  = 7;
	localparam int FREQ_LSB    = 4;
	localparam int OUTSIDE_BIT = 3;
	localparam int FAST_ST_BIT = 2;
	localparam int SLOW_ST_BIT = 1;
	localparam int CHOICE_BIT  = 0;

	localparam int ST_MODE_LSB = 0;
	localparam int ST_FAIL_BIT = 3;
	localparam int ST_OST_BIT  = 4;
	localparam int ST_TWO_BIT  = 5;
	localparam int ST_FAIL_SAFE_CLOCK_MONITOR_BIT = 6;

	localparam logic [2:0] FREQ_RST  = 3'h6;
	localparam logic [2:0] FREQ_MAX  = 3'h7;
	localparam logic [2:0] FREQ_SLOW = 3'h0;

	typedef enum logic [2:0] {
		MODE_DRIVEN, MODE_WATCH, MODE_MED_XTAL, MODE_HIGH_XTAL,
		MODE_RC, MODE_RC_FREE, MODE_INT_CLOCK_OUT_PIN, MODE_INT_FREE
	} sccs_mode_e;

	typedef enum logic [1:0] {GAIN_OFF, GAIN_LOW, GAIN_MED, GAIN_HIGH} sccs_gain_e;

	function automatic logic is_crystal(input sccs_mode_e m);
		return m inside {MODE_WATCH, MODE_MED_XTAL, MODE_HIGH_XTAL};
	endfunction : is_crystal

	function automatic logic is_external(input sccs_mode_e m);
		return !(m inside {MODE_INT_CLOCK_OUT_PIN, MODE_INT_FREE});
	endfunction : is_external

	// Crystal with two-speed, or any fail-safe, starts on internal
	function automatic logic outside_at_reset(input sccs_mode_e m, input logic fse,
		input logic tse);
		return !((tse && is_crystal(m)) || fse);
	endfunction : outside_at_reset

	function automatic logic [6:0] fast_scale(input logic [2:0] f);
		return (7'h01 << (FREQ_MAX - f)) - 7'h01;
	endfunction : fast_scale

	function automatic logic [WARM_W-1:0] warm_step(input logic [WARM_W-1:0] c,
		input logic tick);
		return (tick && c != WARM_TICKS[WARM_W-1:0]) ? c + 1'b1 : c;
	endfunction : warm_step

endpackage : sccs_pkg

// *** hw/sccs_div.sv ***
module sccs_div
	import sccs_pkg::*;
#(
	parameter int W = 8
)(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         en_i,
	input  wire logic [W-1:0] lim_i,
	output logic              tick_o
);

	logic [W-1:0] cnt_r;
	logic         tick_r;
	wire          hit_w = en_i && (cnt_r >= lim_i);

	// Compare by >= so a lowered limit never strands the count
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			tick_r <= hit_w;
			if (en_i)
				cnt_r <= hit_w ? '0 : cnt_r + 1'b1;
		end
	end

	assign tick_o = tick_r;

endmodule : sccs_div

// *** hw/sccs_mon.sv ***
module sccs_mon
	import sccs_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic restart_i,
	input  wire logic pin_i,
	output logic      edge_o,
	output logic      ost_done_o,
	output logic      lost_o
);

	localparam int OST_W  = $clog2(OST_COUNT + 1);
	localparam int IDLE_W = $clog2(FAIL_CYC + 1);

	logic              prev_r;
	logic              edge_r;
	logic [OST_W-1:0]  ost_r;
	logic [IDLE_W-1:0] idle_r;
	wire               rise_w = pin_i && !prev_r;
	wire               ost_full_w = ost_r == OST_COUNT[OST_W-1:0];
	wire               idle_full_w = idle_r == FAIL_CYC[IDLE_W-1:0];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			prev_r <= pin_i; // Tracks the pin, so release shows no false edge
			edge_r <= 1'b0;
			ost_r  <= '0;
			idle_r <= '0;
		end
		else
		begin
			prev_r <= pin_i;
			edge_r <= rise_w;
			if (restart_i)
				ost_r <= '0;
			else if (rise_w && !ost_full_w)
				ost_r <= ost_r + 1'b1;
			if (rise_w)
				idle_r <= '0;
			else if (!idle_full_w)
				idle_r <= idle_r + 1'b1;
		end
	end

	assign edge_o     = edge_r;
	assign ost_done_o = ost_full_w;
	assign lost_o     = idle_full_w;

endmodule : sccs_mon

// *** testbench/sccs_xtal_model.sv ***
module sccs_xtal_model
(
	input  wire logic       clk_i,
	input  wire logic       run_i,
	input  wire logic [3:0] half_i,
	output logic            pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r = 4'h0;
	logic       pin_r = 1'b0;
	assign pin_o = pin_r;
	// A dead oscillator holds its node low, so loss shows as no edges
	always @(posedge clk_i)
	begin
		if (!run_i)
		begin
			pin_r <= 1'b0;
			cnt_r <= 4'h0;
		end
		else if (cnt_r + 4'h1 >= half_i)
		begin
			pin_r <= ~pin_r;
			cnt_r <= 4'h0;
		end
		else
			cnt_r <= cnt_r + 4'h1;
	end
endmodule : sccs_xtal_model

// *** testbench/system_clock_source_selector_tb.sv ***
module system_clock_source_selector_tb;
	import sccs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, wake = 0, run = 0;
	logic        fse = 0, tse = 0, pin;
	logic [3:0]  adr = 4'h0, sel = 4'hf;
	logic [31:0] dat = 32'h0, dat_o, q, seed = 32'h111a;
	logic [2:0]  mode = 3'h0;
	logic [1:0]  gain;
	logic        ack, oe, out, in_free, out_free, tick, exec;
	int          num_errors = 0, cmp_count = 0, cycles = 0, pe, oe_n, tk;
	logic        pp, op;
	always #20 clk_i = ~clk_i;
	sccs_xtal_model partner (.clk_i(clk_i), .run_i(run), .half_i(4'h2), .pin_o(pin));
	sccs_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .cfg_mode_i(mode), .cfg_fail_safe_en_i(fse),
		.cfg_two_speed_en_i(tse), .wake_i(wake), .crystal_in_pin_i(pin),
		.crystal_out_pin_o(out), .crystal_out_pin_oe_o(oe), .crystal_in_free_o(in_free),
		.crystal_out_free_o(out_free), .amp_gain_o(gain), .sys_tick_o(tick),
		.exec_run_o(exec));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	function automatic logic near(input int a, input int b, input int t);
		return (a >= b - t) && (a <= b + t);
	endfunction : near
	// Expected pin use per mode: in_free, out_free, oe, gain
	function automatic logic [4:0] pins_exp(input logic [2:0] m);
		case (m)
			3'h0: return 5'b01_0_00;
			3'h1: return 5'b00_0_01;
			3'h2: return 5'b00_0_10;
			3'h3: return 5'b00_0_11;
			3'h4: return 5'b00_1_00;
			3'h5: return 5'b01_0_00;
			3'h6: return 5'b10_1_00;
			default: return 5'b11_0_00;
		endcase
	endfunction : pins_exp
	task automatic test_done;
		$display("Errors %0d, comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc_wait
	// Request held until ack is sampled high; only the cycle ceiling ends a hang
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1);
		q = dat_o;
		`CHK("ack wait", 2, n)
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic wake_pulse;
		@(posedge clk_i);
		wake <= 1'b1;
		@(posedge clk_i);
		wake <= 1'b0;
	endtask : wake_pulse
	task automatic reset(input logic [2:0] m, input logic f, input logic t, input logic r);
		@(posedge clk_i);
		rst_i <= 1'b1;
		mode <= m;
		fse <= f;
		tse <= t;
		run <= r;
		cyc_wait(3);
		rst_i <= 1'b0;
	endtask : reset
	// Edge counters for the crystal in pin, the system tick and the divided clock output
	task automatic count_edges(input int n);
		pe = 0;
		oe_n = 0;
		tk = 0;
		pp = pin;
		op = out;
		repeat (n)
		begin
			@(posedge clk_i);
			if (pin && !pp)
				pe++;
			if (tick)
				tk++;
			if (out && !op)
				oe_n++;
			pp = pin;
			op = out;
		end
	endtask : count_edges
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles > 60000)
		begin
			num_errors++;
			test_done();
		end
	end
	initial
	begin
		reset(3'h0, 1'b0, 1'b0, 1'b1);
		wb(1'b0, OSC_CTRL_ADR, 8'h0);
		`CHK("osc reset", 8'h68, q[7:0])
		wb(1'b1, OSC_CTRL_ADR, 8'h8e);
		wb(1'b0, OSC_CTRL_ADR, 8'h0);
		`CHK("bit7 ro", 8'h00, q[7:0] & 8'hf1)
		repeat (6)
		begin
			seed = xs(seed);
			wb(1'b1, OSC_CTRL_ADR, {1'b0, seed[2:0], 4'h0});
			wb(1'b0, OSC_CTRL_ADR, 8'h0);
			`CHK("freq", seed[2:0], q[6:4])
		end
		wb(1'b0, 4'h8, 8'h0);
		`CHK("unmapped", 32'h0, q)
		wb(1'b1, OSC_CTRL_ADR, 8'h61);
		cyc_wait(300);
		wb(1'b0, OSC_CTRL_ADR, 8'h0);
		`CHK("internal", 3'b010, q[3:1])
		wb(1'b1, OSC_CTRL_ADR, 8'h60);
		cyc_wait(300);
		wb(1'b0, OSC_CTRL_ADR, 8'h0);
		`CHK("outside", 1'b1, q[3])
		for (int m = 0; m < 8; m++)
		begin
			reset(m[2:0], 1'b0, 1'b0, 1'b1);
			cyc_wait(3);
			`CHK("pins", pins_exp(m[2:0]), {in_free, out_free, oe, gain})
			wb(1'b0, STATUS_ADR, 8'h0);
			`CHK("mode", m[2:0], q[2:0])
		end
		reset(3'h4, 1'b0, 1'b0, 1'b1);
		cyc_wait(50);
		pp = pin;
		op = out;
		count_edges(800);
		`CHK("fosc4", 1'b1, (oe_n * 4 >= pe - 4) && (oe_n * 4 <= pe + 4))
		`CHK("ext tick", 1'b1, near(tk, pe, 1))
		reset(3'h6, 1'b0, 1'b0, 1'b0);
		cyc_wait(3);
		`CHK("int clock_out_pin oe", 1'b1, oe)
		count_edges(600);
		`CHK("fast rate", 1'b1, near(tk, 600 / ((FAST_LIM + 1) << (FREQ_MAX - FREQ_RST)), 1))
		`CHK("int fosc4", 1'b1, near(oe_n * 4, tk, 4))
		wb(1'b1, OSC_CTRL_ADR, 8'h00);
		count_edges(4030);
		`CHK("slow rate", 1'b1, near(tk, 4030 / (SLOW_LIM + 1), 1))
		reset(3'h1, 1'b0, 1'b1, 1'b1);
		wb(1'b0, OSC_CTRL_ADR, 8'h0);
		`CHK("two speed", 1'b0, q[3])
		cyc_wait(4400);
		wb(1'b0, OSC_CTRL_ADR, 8'h0);
		`CHK("two speed ext", 1'b1, q[3])
		wake_pulse();
		cyc_wait(10);
		wb(1'b0, OSC_CTRL_ADR, 8'h0);
		`CHK("wake internal", 1'b0, q[3])
		reset(3'h1, 1'b0, 1'b0, 1'b1);
		cyc_wait(3900);
		`CHK("ost hold", 1'b0, exec)
		cyc_wait(400);
		`CHK("ost done", 1'b1, exec)
		wake_pulse();
		cyc_wait(10);
		`CHK("wake hold", 1'b0, exec)
		reset(3'h0, 1'b0, 1'b0, 1'b1);
		cyc_wait(5);
		`CHK("no ost", 1'b1, exec)
		reset(3'h0, 1'b1, 1'b0, 1'b1);
		wb(1'b0, OSC_CTRL_ADR, 8'h0);
		`CHK("fail_safe_clock_monitor reset", 1'b0, q[3])
		cyc_wait(300);
		run <= 1'b0;
		cyc_wait(100);
		wb(1'b0, STATUS_ADR, 8'h0);
		`CHK("fail flag", 2'b11, {q[ST_FAIL_SAFE_CLOCK_MONITOR_BIT], q[ST_FAIL_BIT]})
		wb(1'b0, OSC_CTRL_ADR, 8'h0);
		`CHK("fail inward", 1'b0, q[3])
		test_done();
	end
endmodule : system_clock_source_selector_tb
